// ### host_model.sv
// host-side serial partner: sends frames into the port, decodes frames
// coming out of it. assumes bit_cyc sys_clk cycles per bit on both sides.
`timescale 1ns/1ps
module host_model #(
  parameter int bit_cyc = 10
) (
  // timing reference
  input  wire logic sys_clk,
  // serial lines
  output logic      host_rx,
  output logic      clear_to_send_in_n,
  input  wire logic host_tx
);
  logic       par_en;
  logic       par_odd;
  logic       stop2;
  logic [7:0] got;
  logic       got_bad;
  int         got_n;

  // ****************************************
  // transmit side
  // ****************************************
  task automatic bit_out(input logic v);
    host_rx <= v;
    repeat (bit_cyc) @(posedge sys_clk);
  endtask

  task automatic send(input logic [7:0] b);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    if (par_en) bit_out(^b ^ par_odd);
    bit_out(1'b1);
    if (stop2) bit_out(1'b1);
  endtask

  // ****************************************
  // receive side
  // ****************************************
  initial begin
    host_rx = 1'b1;
    clear_to_send_in_n = 1'b0;
    par_en = 1'b0;
    par_odd = 1'b0;
    stop2 = 1'b0;
    got = '0;
    got_bad = 1'b0;
    got_n = 0;
    forever begin
      @(negedge host_tx);
      // sample mid-bit, like a real receiver would
      repeat (bit_cyc / 2) @(posedge sys_clk);
      if (host_tx === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cyc) @(posedge sys_clk);
          got[i] = host_tx;
        end
        got_bad = 1'b0;
        if (par_en) begin
          repeat (bit_cyc) @(posedge sys_clk);
          got_bad = host_tx !== (^got ^ par_odd);
        end
        repeat (bit_cyc) @(posedge sys_clk);
        got_bad = got_bad | (host_tx !== 1'b1);
        if (stop2) begin
          repeat (bit_cyc) @(posedge sys_clk);
          got_bad = got_bad | (host_tx !== 1'b1);
        end
        got_n++;
      end
    end
  end
endmodule

// ### uart_break_reset_bypass.sv
// host serial port: 8-bit frames, optional parity, 1 or 2 stop bits,
// rts/cts flow control, break-triggered reset and two-way bypass.
// assumes pin inputs are asynchronous; the apb master is on sys_clk;
// the chip reset controller acts on break_reset_req.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps

module uart_break_reset_bypass
  import uart_brk_pkg::*;
#(
  // cycles per microsecond tick, at least 2 for the strictly-longer test
  parameter int clk_per_us = cyc_per_us
) (
  // clock and reset
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  // apb slave
  input  wire apb_req_t apb_req,
  output apb_rsp_t      apb_rsp,
  // host serial pins
  input  wire logic     host_rx,
  input  wire logic     clear_to_send_in_n,
  output logic          host_tx,
  output logic          host_tx_oe,
  output logic          request_to_send_out_n,
  output logic          request_to_send_oe,
  // bypass gpio pins
  output logic          gpio_tx,
  output logic          gpio_tx_oe,
  input  wire logic     gpio_rx,
  // system
  output logic          break_reset_req,
  output logic          deep_sleep
);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic [1:0] rx_sync;
  logic [1:0] cts_sync;
  logic [1:0] grx_sync;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_sync  <= 2'h3;
      cts_sync <= 2'h3;
      grx_sync <= 2'h3;
    end else begin
      rx_sync  <= {rx_sync[0], host_rx};
      cts_sync <= {cts_sync[0], clear_to_send_in_n};
      grx_sync <= {grx_sync[0], gpio_rx};
    end
  end
  logic rx_s;
  logic cts_n_s;
  assign rx_s    = rx_sync[1];
  assign cts_n_s = cts_sync[1];

  state_t s;
  state_t next_s;

  // ****************************************************************
  // next state
  // ****************************************************************
  logic        acc;
  logic        setup;
  logic        wr;
  logic [17:0] eff_to;
  logic        brk_en;
  always_comb begin
    next_s  = s;
    acc     = apb_req.psel && apb_req.penable;
    setup   = apb_req.psel && !apb_req.penable;
    wr      = acc && apb_req.pwrite;
    // below the floor the feature is off, above the ceiling it clamps
    if (s.timeout < timeout_min) begin
      eff_to = 18'h00000;
    end else if (s.timeout > timeout_max) begin
      eff_to = timeout_max;
    end else begin
      eff_to = s.timeout;
    end
    brk_en = (eff_to != 18'h00000);

    // register bus: decode and read data are registered in the setup
    // cycle, so they stand through the zero-wait access cycle
    next_s.pslverr = 1'b0;
    if (setup && !(apb_req.paddr inside {ctrl_off, baud_off, txdata_off,
        rxdata_off, status_off, timeout_off, bypass_off})) begin
      next_s.pslverr = 1'b1;
    end
    if (wr) begin
      unique case (apb_req.paddr)
        ctrl_off:    next_s.ctrl    = apb_req.pwdata[4:0];
        baud_off:    next_s.baud    = apb_req.pwdata[15:0];
        txdata_off: begin
          next_s.tx_hold = apb_req.pwdata[7:0];
          next_s.tx_pend = 1'b1;
        end
        timeout_off: next_s.timeout = apb_req.pwdata[17:0];
        bypass_off: begin
          if (apb_req.pwdata == bypass_key) begin
            next_s.bypass = 1'b1;
          end
        end
        rxdata_off, status_off: ;
        default:     ;
      endcase
    end
    next_s.prdata = 32'h0000_0000;
    // clear at the capture edge, so a frame landing there is kept
    if (setup && !apb_req.pwrite) begin
      unique case (apb_req.paddr)
        ctrl_off:    next_s.prdata = {27'h0, s.ctrl};
        baud_off:    next_s.prdata = {16'h0, s.baud};
        rxdata_off: begin
          next_s.prdata  = {24'h0, s.rx_data};
          next_s.rx_full = 1'b0;
          next_s.rx_perr = 1'b0;
          next_s.rx_ferr = 1'b0;
        end
        status_off:  next_s.prdata = {26'h0, s.bypass, rx_s, s.rx_ferr,
                                      s.rx_perr, s.rx_full, s.tx_pend};
        timeout_off: next_s.prdata = {14'h0, s.timeout};
        bypass_off:  next_s.prdata = {31'h0, s.bypass};
        txdata_off:  ;
        default:     ;
      endcase
    end

    // break timer in microsecond ticks
    if (!brk_en || rx_s || s.bypass) begin
      next_s.us_cnt = 8'h00;
      next_s.brk_us = 18'h00000;
    end else if (s.us_cnt == 8'(clk_per_us - 1)) begin
      next_s.us_cnt = 8'h00;
      if (s.brk_us != timeout_max) begin
        next_s.brk_us = s.brk_us + 18'd1;
      end
    end else begin
      next_s.us_cnt = s.us_cnt + 8'h01;
    end
    // low for longer than the timeout, so strictly beyond it
    if (brk_en && !s.bypass && !rx_s && s.brk_us >= eff_to &&
        s.us_cnt != 8'h00) begin
      next_s.brk_rst = 1'b1;
    end

    // transmitter
    if (s.tx_cnt != 16'h0000) begin
      next_s.tx_cnt = s.tx_cnt - 16'h0001;
    end
    unique case (s.tx_st)
      st_idle: begin
        next_s.tx_line = !s.ctrl[ctrl_brk];
        if (s.tx_pend && !s.ctrl[ctrl_brk] && !s.bypass &&
            (!s.ctrl[ctrl_flow] || !cts_n_s)) begin
          next_s.tx_sh   = s.tx_hold;
          next_s.tx_pend = 1'b0;
          next_s.tx_line = 1'b0;
          next_s.tx_cnt  = s.baud;
          next_s.tx_st   = st_start;
        end
      end
      st_start: if (s.tx_cnt == 16'h0000) begin
        next_s.tx_line = s.tx_sh[0];
        next_s.tx_bit  = 3'h0;
        next_s.tx_cnt  = s.baud;
        next_s.tx_st   = st_data;
      end
      st_data: if (s.tx_cnt == 16'h0000) begin
        next_s.tx_cnt = s.baud;
        next_s.tx_sh  = {1'b0, s.tx_sh[7:1]};
        if (s.tx_bit != 3'h7) begin
          next_s.tx_bit  = s.tx_bit + 3'h1;
          next_s.tx_line = s.tx_sh[1];
        end else if (s.ctrl[ctrl_par_en]) begin
          next_s.tx_line = ^s.tx_hold ^ s.ctrl[ctrl_par_odd];
          next_s.tx_st   = st_parity;
        end else begin
          next_s.tx_line    = 1'b1;
          next_s.tx_stop2nd = 1'b0;
          next_s.tx_st      = st_stop;
        end
      end
      st_parity: if (s.tx_cnt == 16'h0000) begin
        next_s.tx_cnt     = s.baud;
        next_s.tx_line    = 1'b1;
        next_s.tx_stop2nd = 1'b0;
        next_s.tx_st      = st_stop;
      end
      st_stop: if (s.tx_cnt == 16'h0000) begin
        if (s.ctrl[ctrl_stop2] && !s.tx_stop2nd) begin
          next_s.tx_stop2nd = 1'b1;
          next_s.tx_cnt     = s.baud;
        end else begin
          next_s.tx_st = st_idle;
        end
      end
      default: next_s.tx_st = st_idle;
    endcase
    // a byte written while one is being sent overwrites the holding reg
    if (wr && apb_req.paddr == txdata_off) begin
      next_s.tx_pend = 1'b1;
    end

    // receiver, samples mid-bit
    if (s.rx_cnt != 16'h0000) begin
      next_s.rx_cnt = s.rx_cnt - 16'h0001;
    end
    unique case (s.rx_st)
      st_idle: if (!rx_s && !s.bypass) begin
        next_s.rx_cnt = {1'b0, s.baud[15:1]};
        next_s.rx_st  = st_start;
      end
      st_start: if (s.rx_cnt == 16'h0000) begin
        next_s.rx_cnt = s.baud;
        next_s.rx_bit = 3'h0;
        next_s.rx_par = s.ctrl[ctrl_par_odd];
        next_s.rx_st  = rx_s ? st_idle : st_data;
      end
      st_data: if (s.rx_cnt == 16'h0000) begin
        next_s.rx_cnt = s.baud;
        next_s.rx_sh  = {rx_s, s.rx_sh[7:1]};
        next_s.rx_par = s.rx_par ^ rx_s;
        next_s.rx_bit = s.rx_bit + 3'h1;
        if (s.rx_bit == 3'h7) begin
          next_s.rx_st = s.ctrl[ctrl_par_en] ? st_parity : st_stop;
        end
      end
      st_parity: if (s.rx_cnt == 16'h0000) begin
        next_s.rx_cnt = s.baud;
        next_s.rx_par = s.rx_par ^ rx_s;
        next_s.rx_st  = st_stop;
      end
      st_stop: if (s.rx_cnt == 16'h0000) begin
        // new data wins over a read clear in the same cycle
        next_s.rx_data = s.rx_sh;
        next_s.rx_full = 1'b1;
        next_s.rx_perr = s.ctrl[ctrl_par_en] && s.rx_par;
        next_s.rx_ferr = !rx_s;
        next_s.rx_st   = st_idle;
      end
      default: next_s.rx_st = st_idle;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s         <= '0;
      s.ctrl    <= ctrl_rst;
      s.baud    <= baud_rst;
      s.timeout <= timeout_rst;
      s.bypass  <= 1'b0;
      s.tx_st   <= st_idle;
      s.rx_st   <= st_idle;
      s.tx_line <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  always_comb begin
    apb_rsp.prdata  = s.prdata;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = s.pslverr;
    // released during reset so a shared bus can be driven by others
    host_tx_oe         = !sys_rst;
    request_to_send_oe = !sys_rst;
    host_tx            = s.bypass ? grx_sync[1] : s.tx_line;
    request_to_send_out_n = s.bypass ? 1'b0 : s.rx_full;
    gpio_tx_oe      = s.bypass && !sys_rst;
    gpio_tx         = s.bypass ? rx_s : 1'b1;
    break_reset_req = s.brk_rst;
    deep_sleep      = s.bypass;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  bypass_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.bypass |=> s.bypass) else $error("bypass left without reset");
  bypass_route_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.bypass |-> gpio_tx_oe && gpio_tx == rx_s)
    else $error("bypass routing wrong");
  tristate_rst_a: assert property (@(posedge sys_clk)
    sys_rst |-> !host_tx_oe && !request_to_send_oe)
    else $error("driving while in reset");
  zero_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !brk_en |=> s.brk_us == 18'h0 && !$rose(s.brk_rst))
    else $error("break active while disabled");
  floor_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.timeout < timeout_min |-> eff_to == 18'h0)
    else $error("small timeout not zero");
  clamp_max_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.timeout > timeout_max |-> eff_to == timeout_max)
    else $error("timeout not clamped");
  counter_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_s |=> s.brk_us == 18'h0 && s.us_cnt == 8'h0)
    else $error("break counter not restarted");
  brk_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s.brk_rst) |-> !$past(rx_s) && $past(s.brk_us) >= eff_to)
    else $error("reset without long break");
  flow_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.tx_st == st_idle && s.ctrl[ctrl_flow] && cts_n_s |=> s.tx_st == st_idle)
    else $error("sent while cts high");
  brk_line_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.ctrl[ctrl_brk] && s.tx_st == st_idle ##1 s.ctrl[ctrl_brk]
    |-> !s.tx_line) else $error("break not driven");
  stop_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s.tx_st == st_stop |-> s.tx_line) else $error("stop bit low");

  tx_frame_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    s.tx_st == st_stop ##1 s.tx_st == st_idle);
  rx_frame_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s.rx_full));
  brk_rst_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s.brk_rst));
  bypass_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s.bypass));

endmodule

// ### uart_break_reset_bypass_tb_top.sv
// testbench: apb accesses plus host-side serial traffic, with checks.
// assumes the package constants and one 200 MHz clock.
`timescale 1ns/1ps
module uart_break_reset_bypass_tb_top
  import uart_brk_pkg::*;
;
  logic      sys_clk;
  logic      sys_rst;
  apb_req_t  apb_req;
  apb_rsp_t  apb_rsp;
  wire logic host_rx;
  wire logic cts_n;
  logic      host_tx;
  logic      host_tx_oe;
  logic      rts_n;
  logic      rts_oe;
  logic      gpio_tx;
  logic      gpio_tx_oe;
  logic      gpio_rx;
  logic      brk_req;
  logic      deep_sleep;
  int        err_total;
  int        tests_run;
  int        n0;
  logic [31:0] rd;
  logic        serr;
  logic [4:0]  modes [4] = '{5'h00, 5'h01, 5'h03, 5'h04};

  // fast microsecond tick keeps the break reset tests short
  uart_break_reset_bypass #(.clk_per_us(2)) i_uart_break_reset_bypass (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .host_rx(host_rx), .clear_to_send_in_n(cts_n),
    .host_tx(host_tx), .host_tx_oe(host_tx_oe),
    .request_to_send_out_n(rts_n), .request_to_send_oe(rts_oe),
    .gpio_tx(gpio_tx), .gpio_tx_oe(gpio_tx_oe), .gpio_rx(gpio_rx),
    .break_reset_req(brk_req), .deep_sleep(deep_sleep));

  host_model #(.bit_cyc(10)) i_host_model (
    .sys_clk(sys_clk), .host_rx(host_rx),
    .clear_to_send_in_n(cts_n), .host_tx(host_tx));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // data and error are taken at the edge that completes the access
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    apb_req.paddr <= a;
    apb_req.pwrite <= w;
    apb_req.pwdata <= d;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk);
    while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
    rd = apb_rsp.prdata;
    serr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic wait_tx();
    for (int k = 0; k < 3000 && i_host_model.got_n == n0; k++)
      @(posedge sys_clk);
  endtask

  task automatic low_hold();
    i_host_model.host_rx <= 1'b0;
    repeat (3000) @(posedge sys_clk);
    chk("break reset req", 32'h0, brk_req);
    i_host_model.host_rx <= 1'b1;
    repeat (50) @(posedge sys_clk);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    apb_req = '0;
    gpio_rx = 1'b1;
    repeat (11) @(posedge sys_clk);
    chk("oe in reset", 3'b000, {host_tx_oe, rts_oe, gpio_tx_oe});
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("oe after reset", 4'b1100,
        {host_tx_oe, rts_oe, gpio_tx_oe, deep_sleep});
    chk("tx idle", 32'h1, host_tx);
    rdchk("ctrl", ctrl_off, {27'h0, ctrl_rst});
    rdchk("baud", baud_off, {16'h0, baud_rst});
    rdchk("timeout", timeout_off, 32'h0);
    xfer(12'h020, 1'b0, 32'h0);
    chk("unmapped", 32'h1, serr);
    xfer(baud_off, 1'b1, 32'h9);
    rdchk("baud wr", baud_off, 32'h9);
    // cts high must hold the character back
    i_host_model.clear_to_send_in_n <= 1'b1;
    n0 = i_host_model.got_n;
    xfer(txdata_off, 1'b1, 32'h55);
    repeat (60) @(posedge sys_clk);
    chk("tx held", 32'h1, host_tx);
    i_host_model.clear_to_send_in_n <= 1'b0;
    wait_tx();
    chk("tx after cts", 32'h55, i_host_model.got);
    for (int i = 0; i < 4; i++) begin
      i_host_model.par_en = modes[i][0];
      i_host_model.par_odd = modes[i][1];
      i_host_model.stop2 = modes[i][2];
      xfer(ctrl_off, 1'b1, {27'h0, modes[i]});
      n0 = i_host_model.got_n;
      xfer(txdata_off, 1'b1, 32'ha5 ^ i);
      wait_tx();
      chk("tx data", 32'ha5 ^ i, i_host_model.got);
      chk("tx frame", 32'h0, i_host_model.got_bad);
      i_host_model.send(8'h3c + 8'(i));
      repeat (5) @(posedge sys_clk);
      chk("rts when full", 32'h1, rts_n);
      rdchk("rx data", rxdata_off, 32'h3c + i);
    end
    xfer(ctrl_off, 1'b1, 32'h10);
    repeat (100) @(posedge sys_clk);
    chk("break tx", 32'h0, host_tx);
    repeat (200) @(posedge sys_clk);
    chk("break held", 32'h0, host_tx);
    xfer(ctrl_off, 1'b1, 32'h0);
    repeat (200) @(posedge sys_clk);
    chk("break end", 32'h1, host_tx);
    low_hold();
    xfer(timeout_off, 1'b1, 32'd999);
    low_hold();
    xfer(timeout_off, 1'b1, 32'h3ffff);
    rdchk("timeout raw", timeout_off, 32'h3ffff);
    xfer(timeout_off, 1'b1, 32'd1000);
    // a short low, a release, then a low checked just short of and just past the timeout
    i_host_model.host_rx <= 1'b0;
    repeat (1500) @(posedge sys_clk);
    i_host_model.host_rx <= 1'b1;
    repeat (20) @(posedge sys_clk);
    i_host_model.host_rx <= 1'b0;
    repeat (1980) @(posedge sys_clk);
    chk("break restart", 32'h0, brk_req);
    repeat (40) @(posedge sys_clk);
    chk("break reset req", 32'h1, brk_req);
    i_host_model.host_rx <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("break cleared", 32'h0, brk_req);
    xfer(bypass_off, 1'b1, bypass_key);
    repeat (5) @(posedge sys_clk);
    chk("bypass pins", 3'b110, {deep_sleep, gpio_tx_oe, rts_n});
    i_host_model.host_rx <= 1'b0;
    gpio_rx <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("route low", 2'b00, {gpio_tx, host_tx});
    i_host_model.host_rx <= 1'b1;
    gpio_rx <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("route high", 2'b11, {gpio_tx, host_tx});
    rdchk("status", status_off, 32'h30);
    xfer(bypass_off, 1'b1, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk("bypass sticky", 32'h1, deep_sleep);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("hard reset", 2'b00, {deep_sleep, gpio_tx_oe});
    end_sim();
  end
endmodule

// ### uart_brk_pkg.sv
// package: register map, field layout and timing constants of the
// host serial port with break reset and bypass.
// assumes a 200 MHz system clock and an apb master with 32-bit data.
package uart_brk_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ctrl_off     = 12'h000;
  localparam logic [11:0] baud_off     = 12'h004;
  localparam logic [11:0] txdata_off   = 12'h008;
  localparam logic [11:0] rxdata_off   = 12'h00c;
  localparam logic [11:0] status_off   = 12'h010;
  localparam logic [11:0] timeout_off  = 12'h014;
  localparam logic [11:0] bypass_off   = 12'h018;
  localparam logic [15:0] break_reset_timeout_key = 16'h01a4;

  // ****************************************************************
  // control fields and reset values
  // ****************************************************************
  localparam int ctrl_par_en  = 0;
  localparam int ctrl_par_odd = 1;
  localparam int ctrl_stop2   = 2;
  localparam int ctrl_flow    = 3;
  localparam int ctrl_brk     = 4;
  localparam logic [4:0]  ctrl_rst     = 5'h08;
  localparam logic [15:0] baud_rst     = 16'h00ad;
  localparam logic [17:0] timeout_rst  = 18'h00000;
  localparam logic [31:0] bypass_key   = 32'h0000_b1a5;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int clk_mhz      = 200;
  localparam int us_per_unit  = 1;
  localparam int cyc_per_us   = clk_mhz * us_per_unit;
  localparam logic [17:0] timeout_min = 18'd1000;
  localparam logic [17:0] timeout_max = 18'd255000;

  typedef enum logic [4:0] {
    st_idle   = 5'b00001,
    st_start  = 5'b00010,
    st_data   = 5'b00100,
    st_parity = 5'b01000,
    st_stop   = 5'b10000
  } ser_st_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] baud;
    logic [17:0] timeout;
    logic        bypass;
    ser_st_t     tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_stop2nd;
    logic        tx_line;
    logic        tx_pend;
    logic [7:0]  tx_hold;
    ser_st_t     rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        rx_perr;
    logic        rx_ferr;
    logic [7:0]  us_cnt;
    logic [17:0] brk_us;
    logic        brk_rst;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;

endpackage
